// File: rtl/ums_spi_master.sv
/*
 * Master-only SPI engine of the serial port, with its control registers,
 * a double-buffered transmitter and a two-level receive buffer.
 * Assumes one clock domain, a synchronous active-low reset, a register
 * port with one-cycle strobes, and an external slave-select.
 */
// Operation
// - Framing, overrun and parity error bits always read as zero
// - Receive-done is high exactly while unread receive data remains
// - Transmit-done sets when the frame ends with transmit buffer empty
// - Transmit-done clears on interrupt service or software writing one
// - Buffer-empty is high when buffer accepts a byte, high after reset
// - Receive interrupt needs enable, receive-done and global flag
// - Transmit-done interrupt needs enable, flag and global flag
// - Buffer-empty interrupt needs enable, flag and global flag
// - Receiver enable takes the serial input pin from the port
// - Clearing receiver enable flushes the receive buffer
// - Receiver alone never starts clocks or transfers
// - Transmitter disable waits for shifting and buffered bytes
// - Mode field: 00 async, 01 sync, 10 reserved, 11 master SPI
// - Order, phase and polarity take effect in the mode-select write
// - Bit order one sends LSB first, zero sends MSB first
// - Phase bit selects sampling on leading or trailing clock edge
// - Transmit path is double buffered
// - Receive path holds two levels beyond the byte being assembled
// - Master only, no slave-select pin handling
// - Polarity bit sets the idle level of the transfer clock
// - Each accepted data write starts one full-duplex transfer when shifter frees in master SPI mode
// - On receive overflow the newest byte is lost, older ones kept
// - Frames are eight bits; data line rests high while idle
`timescale 1ns/10ps
module ums_spi_master #(
    parameter int RX_DEPTH = ums_pkg::RX_DEPTH,
    parameter int BAUD_W   = 8
) (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    input  wire logic       global_irq_enable_in,
    input  wire logic       tx_irq_serviced_in,
    input  wire logic       serial_in_pin_in,
    output logic      [7:0] rd_data_out,
    output logic            rx_irq_out,
    output logic            tx_done_irq_out,
    output logic            buf_empty_irq_out,
    output logic            transfer_clock_pin_out,
    output logic            serial_out_pin_out,
    output logic            serial_out_oe_b_out,
    output logic            serial_in_take_out,
    output logic            master_spi_mode_out
);

    localparam int CNT_W = $clog2(RX_DEPTH + 1);

    // ************************************************************
    // Registers and nets
    // ************************************************************
    logic                  rxcie_q;
    logic                  txcie_q;
    logic                  buffer_empty_irq_enable_q;
    logic                  rx_on_q;
    logic                  tx_on_q;
    logic [1:0]            mode_q;
    logic                  order_q;
    logic                  cpha_q;
    logic                  cpol_q;
    logic [BAUD_W-1:0]     baud_q;
    logic                  txc_q;
    logic                  tx_full_q;
    logic [7:0]            tx_buf_q;
    logic [7:0]            tx_sh_q;
    logic [7:0]            rx_sh_q;
    logic [7:0]            rx_byte;
    logic [7:0]            rx_mem_q [RX_DEPTH];
    logic [CNT_W-1:0]      rx_cnt_q;
    logic [CNT_W-1:0]      rx_keep;
    ums_pkg::ums_state_type state_q;
    logic                  phase_q;
    logic [2:0]            bit_cnt_q;
    logic [BAUD_W-1:0]     div_q;
    logic                  sck_q;
    logic                  mosi_q;
    logic                  miso_s1_q;
    logic                  miso_s2_q;
    logic [7:0]            rd_data_q;
    logic                  rx_irq_q;
    logic                  tx_irq_q;
    logic                  be_irq_q;
    logic                  oe_b_q;
    logic                  take_q;
    logic                  mspi_q;
    logic                  busy;
    logic                  mspi;
    logic                  tick;
    logic                  lead;
    logic                  trail;
    logic                  sample;
    logic                  frame_end;
    logic                  start;
    logic                  wr_data;
    logic                  wr_status;
    logic                  wr_enable;
    logic                  wr_format;
    logic                  accept;
    logic                  rx_pop;
    logic                  rx_push;
    logic                  rx_flush;
    logic                  rxc;
    logic [2:0]            pos;

    // Bit of a byte sent at a given step, for either order
    function automatic logic pick_bit(input logic [7:0] byte_v,
                                      input logic [2:0] idx,
                                      input logic       lsb_first);
        logic [2:0] p;
        p = lsb_first ? idx : 3'h7 - idx;
        return byte_v[p];
    endfunction : pick_bit

    // ************************************************************
    // Decode
    // ************************************************************
    // Strobe decode and engine events
    assign wr_data   = wr_en_in && (addr_in == ums_pkg::OFF_DATA);
    assign wr_status = wr_en_in && (addr_in == ums_pkg::OFF_STATUS);
    assign wr_enable = wr_en_in && (addr_in == ums_pkg::OFF_ENABLE);
    assign wr_format = wr_en_in && (addr_in == ums_pkg::OFF_FORMAT);
    assign mspi      = (mode_q == ums_pkg::MODE_MSPI);
    assign busy      = (state_q == ums_pkg::ST_SHIFT);
    assign tick      = busy && (div_q == baud_q);
    assign lead      = tick && !phase_q;
    assign trail     = tick && phase_q;
    assign sample    = cpha_q ? trail : lead;
    assign frame_end = trail && (bit_cnt_q == 3'(ums_pkg::FRAME_BITS - 1));
    // Only a buffered byte starts a frame
    assign start     = !busy && tx_full_q && mspi;
    // Data writes accepted while the transmitter is on
    assign accept    = wr_data && tx_on_q && !tx_full_q;
    assign pos       = order_q ? bit_cnt_q : 3'h7 - bit_cnt_q;
    assign rxc       = (rx_cnt_q != '0);

    // ************************************************************
    // Control registers
    // ************************************************************
    // Enable bits
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rxcie_q <= ums_pkg::ENABLE_RESET[ums_pkg::EN_RXCIE];
            txcie_q <= ums_pkg::ENABLE_RESET[ums_pkg::EN_TXCIE];
            buffer_empty_irq_enable_q <= ums_pkg::ENABLE_RESET[ums_pkg::EN_BUFFER_EMPTY_IRQ_ENABLE];
            rx_on_q <= ums_pkg::ENABLE_RESET[ums_pkg::EN_RXEN];
            tx_on_q <= ums_pkg::ENABLE_RESET[ums_pkg::EN_TXEN];
        end else if (wr_enable) begin
            rxcie_q <= wr_data_in[ums_pkg::EN_RXCIE];
            txcie_q <= wr_data_in[ums_pkg::EN_TXCIE];
            buffer_empty_irq_enable_q <= wr_data_in[ums_pkg::EN_BUFFER_EMPTY_IRQ_ENABLE];
            rx_on_q <= wr_data_in[ums_pkg::EN_RXEN];
            tx_on_q <= wr_data_in[ums_pkg::EN_TXEN];
        end
    end

    // Format fields load together with the mode field
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            mode_q  <= ums_pkg::FORMAT_RESET[ums_pkg::FMT_MODE_H:ums_pkg::FMT_MODE_L];
            order_q <= ums_pkg::FORMAT_RESET[ums_pkg::FMT_ORDER];
            cpha_q  <= ums_pkg::FORMAT_RESET[ums_pkg::FMT_CPHA];
            cpol_q  <= ums_pkg::FORMAT_RESET[ums_pkg::FMT_CPOL];
        end else if (wr_format) begin
            mode_q  <= wr_data_in[ums_pkg::FMT_MODE_H:ums_pkg::FMT_MODE_L];
            order_q <= wr_data_in[ums_pkg::FMT_ORDER];
            cpha_q  <= wr_data_in[ums_pkg::FMT_CPHA];
            cpol_q  <= wr_data_in[ums_pkg::FMT_CPOL];
        end
    end

    // Baud divisor
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            baud_q <= BAUD_W'(ums_pkg::BAUD_RESET);
        end else if (wr_en_in && (addr_in == ums_pkg::OFF_BAUD)) begin
            baud_q <= BAUD_W'(wr_data_in);
        end
    end

    // ************************************************************
    // Transmit buffer and flags
    // ************************************************************
    // Holding buffer in front of the shifter
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            tx_full_q <= 1'b0;
            tx_buf_q  <= 8'h00;
        end else if (start) begin
            tx_full_q <= 1'b0;
        end else if (accept) begin
            tx_full_q <= 1'b1;
            tx_buf_q  <= wr_data_in;
        end
    end

    // Set on frame end with nothing queued; set wins over clear
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            txc_q <= 1'b0;
        end else if (frame_end && !tx_full_q && !accept) begin
            txc_q <= 1'b1;
        // Cleared by service or a one written
        end else if (tx_irq_serviced_in || (wr_status && wr_data_in[ums_pkg::ST_TXC])) begin
            txc_q <= 1'b0;
        end
    end

    // ************************************************************
    // Transfer engine
    // ************************************************************
    // Half-period divider and edge sequencing
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            state_q   <= ums_pkg::ST_IDLE;
            phase_q   <= 1'b0;
            bit_cnt_q <= 3'h0;
            div_q     <= '0;
            tx_sh_q   <= 8'h00;
        end else begin
            case (state_q)
                ums_pkg::ST_IDLE: begin
                    // Buffer moves into the free shifter
                    if (start) begin
                        state_q   <= ums_pkg::ST_SHIFT;
                        phase_q   <= 1'b0;
                        bit_cnt_q <= 3'h0;
                        div_q     <= '0;
                        tx_sh_q   <= tx_buf_q;
                    end
                end
                ums_pkg::ST_SHIFT: begin
                    div_q <= tick ? '0 : div_q + 1'b1;
                    if (tick) begin
                        phase_q <= !phase_q;
                    end
                    if (trail) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                    end
                    // Frame always runs to its end
                    if (frame_end) begin
                        state_q <= ums_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ums_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Clock rests at polarity, toggles on each half period
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            sck_q <= 1'b0;
        end else if (tick) begin
            sck_q <= !sck_q;
        end else if (!busy) begin
            sck_q <= cpol_q;
        end
    end

    // Output bit selection; phase 1 holds the last bit through its sampling edge
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            mosi_q <= 1'b1;
        end else if ((frame_end && !cpha_q) || (!busy && !start)) begin
            mosi_q <= 1'b1;                       // Line rests high
        end else if (start && !cpha_q) begin
            mosi_q <= pick_bit(tx_buf_q, 3'h0, order_q);
        end else if (lead && cpha_q) begin
            mosi_q <= pick_bit(tx_sh_q, bit_cnt_q, order_q);
        end else if (trail && !cpha_q) begin
            mosi_q <= pick_bit(tx_sh_q, bit_cnt_q + 3'h1, order_q);
        end
    end

    // ************************************************************
    // Receive path
    // ************************************************************
    // Input pin synchroniser
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else begin
            miso_s1_q <= serial_in_pin_in;
            miso_s2_q <= miso_s1_q;
        end
    end

    // Byte under assembly including the bit sampled now
    always_comb begin
        rx_byte = rx_sh_q;
        if (sample) begin
            rx_byte[pos] = miso_s2_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rx_sh_q <= 8'h00;
        end else if (tick) begin
            rx_sh_q <= rx_byte;
        end
    end

    // Flush on a write clearing the receiver, or while off
    assign rx_flush = !rx_on_q || (wr_enable && !wr_data_in[ums_pkg::EN_RXEN]);
    assign rx_pop   = rd_en_in && (addr_in == ums_pkg::OFF_DATA) && rxc;
    assign rx_keep  = rx_cnt_q - CNT_W'(rx_pop);
    // A full buffer drops the newest byte
    assign rx_push  = frame_end && rx_on_q && (rx_keep < CNT_W'(RX_DEPTH));

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rx_cnt_q <= '0;
        end else if (rx_flush) begin
            rx_cnt_q <= '0;
        end else begin
            rx_cnt_q <= rx_keep + CNT_W'(rx_push);
        end
    end

    // Receive buffer entries, head at index zero
    for (genvar gi = 0; gi < RX_DEPTH; gi++) begin : g_rx
        always_ff @(posedge clock_in) begin
            if (rx_push && (rx_keep == CNT_W'(gi))) begin
                rx_mem_q[gi] <= rx_byte;
            end else if (rx_pop) begin
                if (gi < RX_DEPTH - 1) begin
                    rx_mem_q[gi] <= rx_mem_q[(gi + 1) % RX_DEPTH];
                end
            end
        end
    end

    // ************************************************************
    // Read port and outputs
    // ************************************************************
    // Error bits read as zero
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rd_data_q <= 8'h00;
        end else if (rd_en_in) begin
            case (addr_in)
                ums_pkg::OFF_DATA:   rd_data_q <= rxc ? rx_mem_q[0] : 8'h00;
                ums_pkg::OFF_STATUS: rd_data_q <= {rxc, txc_q, !tx_full_q, 5'h00};
                ums_pkg::OFF_ENABLE: rd_data_q <= {rxcie_q, txcie_q, buffer_empty_irq_enable_q, rx_on_q,
                                                   tx_on_q, ums_pkg::ENABLE_RSVD};
                ums_pkg::OFF_FORMAT: rd_data_q <= {mode_q, 3'h0, order_q, cpha_q, cpol_q};
                ums_pkg::OFF_BAUD:   rd_data_q <= 8'(baud_q);
                default:             rd_data_q <= 8'h00;
            endcase
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rx_irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
            be_irq_q <= 1'b0;
        end else begin
            rx_irq_q <= global_irq_enable_in && rxcie_q && rxc;
            tx_irq_q <= global_irq_enable_in && txcie_q && txc_q;
            be_irq_q <= global_irq_enable_in && buffer_empty_irq_enable_q && !tx_full_q;
        end
    end

    // Pin ownership; no slave select driven
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            oe_b_q <= 1'b1;
            take_q <= 1'b0;
            mspi_q <= 1'b0;
        end else begin
            oe_b_q <= !(tx_on_q || busy || tx_full_q);
            take_q <= rx_on_q;
            mspi_q <= mspi;
        end
    end

    assign rd_data_out            = rd_data_q;
    assign rx_irq_out             = rx_irq_q;
    assign tx_done_irq_out        = tx_irq_q;
    assign buf_empty_irq_out      = be_irq_q;
    assign transfer_clock_pin_out = sck_q;
    assign serial_out_pin_out     = mosi_q;
    assign serial_out_oe_b_out    = oe_b_q;
    assign serial_in_take_out     = take_q;
    assign master_spi_mode_out    = mspi_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    logic [4:0] edge_cnt_q;                        // Clock edges in frame
    always_ff @(posedge clock_in) begin
        if (!rst_b_in || start) begin
            edge_cnt_q <= 5'h00;
        end else if (tick) begin
            edge_cnt_q <= edge_cnt_q + 5'h01;
        end
    end

    a_err_bits_zero: assert property (rd_en_in && addr_in == ums_pkg::OFF_STATUS
        |=> rd_data_out[4:0] == 5'h00) else $error("error bits not zero");
    a_txc_clear: assert property (tx_irq_serviced_in && !frame_end
        |=> !txc_q) else $error("transmit-done not cleared");
    a_udre_write: assert property (accept && !start
        |=> tx_full_q && tx_buf_q == $past(wr_data_in)) else $error("buffer-empty stuck");
    a_rx_irq_gate: assert property (rx_irq_out
        |-> $past(global_irq_enable_in && rxcie_q && rxc)) else $error("bad rx irq");
    a_tx_irq_gate: assert property (tx_done_irq_out
        |-> $past(global_irq_enable_in && txcie_q && txc_q)) else $error("bad txc irq");
    a_be_irq_gate: assert property (buf_empty_irq_out
        |-> $past(global_irq_enable_in && buffer_empty_irq_enable_q && !tx_full_q)) else $error("bad udre irq");
    a_rx_flush: assert property (wr_enable && !wr_data_in[ums_pkg::EN_RXEN]
        |=> !rxc [*2]) else $error("receive buffer not flushed");
    a_overrun_keep: assert property (frame_end && rx_on_q && !rx_flush
        && rx_cnt_q == CNT_W'(RX_DEPTH) && !rx_pop
        |=> rx_cnt_q == CNT_W'(RX_DEPTH) && $stable(rx_mem_q[0])) else $error("overrun lost old");
    a_frame_edges: assert property (frame_end
        |-> edge_cnt_q == 5'h0f) else $error("frame is not eight clocks");
    a_idle_clock: assert property (!busy && $past(!busy) && $stable(cpol_q)
        |-> transfer_clock_pin_out == cpol_q && serial_out_pin_out) else $error("idle level");
    a_tx_release: assert property ($rose(serial_out_oe_b_out)
        |-> $past(!busy && !tx_full_q && !tx_on_q)) else $error("early pin release");

endmodule : ums_spi_master

// File: rtl/ums_pkg.sv
/*
 * Constants for the master-only SPI mode of the serial port: register
 * offsets, bit positions, reset values, mode codes and engine states.
 * Assumes a byte-wide register port with a three-bit address.
 */
package ums_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W     = 3;
    localparam logic [2:0]  OFF_DATA   = 3'h0;    // data_buffer_register
    localparam logic [2:0]  OFF_STATUS = 3'h1;    // spi_status_flags
    localparam logic [2:0]  OFF_ENABLE = 3'h2;    // spi_enable_control
    localparam logic [2:0]  OFF_FORMAT = 3'h3;    // spi_format_control
    localparam logic [2:0]  OFF_BAUD   = 3'h4;    // Baud divisor

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int ST_RXC     = 7;
    localparam int ST_TXC     = 6;
    localparam int ST_UDRE    = 5;
    localparam int EN_RXCIE   = 7;
    localparam int EN_TXCIE   = 6;
    localparam int EN_BUFFER_EMPTY_IRQ_ENABLE   = 5;
    localparam int EN_RXEN    = 4;
    localparam int EN_TXEN    = 3;
    localparam int FMT_MODE_H = 7;
    localparam int FMT_MODE_L = 6;
    localparam int FMT_ORDER  = 2;
    localparam int FMT_CPHA   = 1;
    localparam int FMT_CPOL   = 0;

    // ************************************************************
    // Reset values and codes
    // ************************************************************
    localparam logic [7:0] ENABLE_RESET = 8'h06;
    localparam logic [7:0] FORMAT_RESET = 8'h06;
    localparam logic [2:0] ENABLE_RSVD  = 3'h6;  // Read value of bits 2:0
    localparam logic [7:0] BAUD_RESET   = 8'h00;
    localparam logic [1:0] MODE_ASYNC   = 2'h0;
    localparam logic [1:0] MODE_SYNC    = 2'h1;
    localparam logic [1:0] MODE_RSVD    = 2'h2;
    localparam logic [1:0] MODE_MSPI    = 2'h3;
    localparam int         FRAME_BITS   = 8;
    localparam int         RX_DEPTH     = 2;

    // Transfer engine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } ums_state_type;

endpackage : ums_pkg

// File: testbench/ums_slave_model.sv
/* Slave on the serial lines: shifts out a counting byte, captures the master's byte.
   Assumes the bench sets the mode bits and calls load between frames. */
`timescale 1ns/10ps
module ums_slave_model (
    input  wire logic sck_in,
    input  wire logic mosi_in,
    input  wire logic cpol_in,
    input  wire logic cpha_in,
    input  wire logic lsb_in,
    output logic      miso_out
);
    logic [7:0] tx_q = 8'h00;
    logic [7:0] rx_q = 8'h00;
    int         idx  = 0;
    int         cnt  = 0;
    logic [7:0] got_q[$];
    initial miso_out = 1'b0;
    // Phase 0 needs the first bit before the leading edge
    task automatic load(input logic [7:0] b);
        tx_q = b;
        cnt = 0;
        idx = cpha_in ? 0 : 1;
        if (!cpha_in) miso_out = lsb_in ? b[0] : b[7];
    endtask : load
    // sample and setup edges follow phase, polarity and order
    always @(sck_in) begin
        if ((sck_in !== cpol_in) == !cpha_in) begin
            rx_q = lsb_in ? {mosi_in, rx_q[7:1]} : {rx_q[6:0], mosi_in};
            cnt++;
            // eight bits a frame, next byte counts up
            if (cnt == 8) begin
                got_q.push_back(rx_q);
                cnt = 0;
                idx = 0;
                tx_q++;
            end
        end else if (idx < 8) begin
            miso_out = lsb_in ? tx_q[idx] : tx_q[7-idx];
            idx++;
        end else miso_out = ~miso_out;
    end
endmodule : ums_slave_model

// File: testbench/tb_usart_master_spi_mode.sv
/* Self-checking bench for the master SPI port, with a slave model on the pins.
   Assumes a 125 MHz clock and baud 4, giving an 80 ns transfer clock. */
`timescale 1ns/10ps
module tb_usart_master_spi_mode;
    logic       clock_in = 0, rst_b_in = 0, wr_en = 0, rd_en = 0, gie = 0, svc = 0;
    logic [2:0] addr = 0;
    logic [7:0] wdata = 0, rdata, rb, s, d, fmt_q = 8'h06;
    logic       rx_irq, tx_irq, be_irq, sck, mosi, oe_b, take, mspi, miso;
    int         err_total = 0, checks_done = 0, cyc = 0, seed = 32'he5dd, k;
    logic [7:0] exp_q[$], wq[$];
    always #4 clock_in = ~clock_in;
    ums_spi_master dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .global_irq_enable_in(gie),
        .tx_irq_serviced_in(svc), .serial_in_pin_in(miso), .rd_data_out(rdata),
        .rx_irq_out(rx_irq), .tx_done_irq_out(tx_irq), .buf_empty_irq_out(be_irq),
        .transfer_clock_pin_out(sck), .serial_out_pin_out(mosi), .serial_out_oe_b_out(oe_b),
        .serial_in_take_out(take), .master_spi_mode_out(mspi));
    ums_slave_model slv (.sck_in(sck), .mosi_in(mosi), .cpol_in(fmt_q[0]),
        .cpha_in(fmt_q[1]), .lsb_in(fmt_q[2]), .miso_out(miso));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock_in);
        {addr, wdata, wr_en} <= {a, v, 1'b1};
        @(posedge clock_in);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clock_in);
        {addr, rd_en} <= {a, 1'b1};
        @(posedge clock_in);
        rd_en <= 1'b0;
        #1 rb = rdata;
    endtask : rd
    // Poll a status bit with a bounded count
    task automatic wait_bit(input int b);
        k = 0;
        do begin
            rd(ums_pkg::OFF_STATUS);
            k++;
        end while (rb[b] !== 1'b1 && k < 300);
    endtask : wait_bit
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rd(ums_pkg::OFF_STATUS);
        chk(rb, 8'h20);
        chk({7'h00, mspi}, 8'h00);
        rd(ums_pkg::OFF_ENABLE);
        chk(rb, ums_pkg::ENABLE_RESET);
        rd(ums_pkg::OFF_FORMAT);
        chk(rb, ums_pkg::FORMAT_RESET);
        rd(3'h7);
        chk(rb, 8'h00);
        wr(ums_pkg::OFF_BAUD, 8'h04);
        wr(ums_pkg::OFF_ENABLE, 8'h18);
        // Every phase, polarity and order, set in the mode-select write
        for (int m = 0; m < 8; m++) begin
            fmt_q = {2'b11, 3'b000, m[2:0]};
            wr(ums_pkg::OFF_FORMAT, fmt_q);
            repeat (3) @(posedge clock_in);
            chk({mspi, sck}, {1'b1, fmt_q[0]});
            s = $random(seed);
            d = $random(seed);
            slv.load(s);
            wr(ums_pkg::OFF_STATUS, 8'h40);
            wr(ums_pkg::OFF_DATA, d);
            wait_bit(6);
            chk(rb, 8'he0);
            rd(ums_pkg::OFF_DATA);
            chk(rb, s);
            chk(slv.got_q.pop_front(), d);
            wr(ums_pkg::OFF_STATUS, 8'h40);
            rd(ums_pkg::OFF_STATUS);
            chk(rb, 8'h20);
        end
        // Three frames left unread: the newest one is dropped
        s = $random(seed);
        slv.load(s);
        for (int i = 0; i < 3; i++) begin
            wait_bit(5);
            d = $random(seed);
            wq.push_back(d);
            wr(ums_pkg::OFF_DATA, d);
            if (exp_q.size() < 2) exp_q.push_back(s + 8'(i));
        end
        wait_bit(6);
        for (int i = 0; i < 3; i++) chk(slv.got_q.pop_front(), wq.pop_front());
        for (int i = 0; i < 2; i++) begin
            rd(ums_pkg::OFF_DATA);
            chk(rb, exp_q.pop_front());
        end
        rd(ums_pkg::OFF_STATUS);
        chk(rb, 8'h60);
        // Interrupt requests, service and global gating
        wr(ums_pkg::OFF_ENABLE, 8'hf8);
        gie <= 1'b1;
        s = $random(seed);
        slv.load(s);
        wr(ums_pkg::OFF_STATUS, 8'h40);
        wr(ums_pkg::OFF_DATA, s);
        wait_bit(6);
        repeat (2) @(posedge clock_in);
        chk({rx_irq, tx_irq, be_irq, take}, 4'hf);
        svc <= 1'b1;
        @(posedge clock_in);
        svc <= 1'b0;
        repeat (2) @(posedge clock_in);
        chk({rx_irq, tx_irq}, 2'b10);
        gie <= 1'b0;
        repeat (2) @(posedge clock_in);
        chk({rx_irq, tx_irq, be_irq}, 3'b000);
        wr(ums_pkg::OFF_ENABLE, 8'h08);
        rd(ums_pkg::OFF_STATUS);
        chk({rb, 7'h00, take}, 16'h2000);
        // Transmitter off with a frame under way keeps the pin
        wr(ums_pkg::OFF_DATA, s);
        wr(ums_pkg::OFF_ENABLE, 8'h00);
        repeat (2) @(posedge clock_in);
        chk({7'h00, oe_b}, 8'h00);
        wait_bit(6);
        repeat (3) @(posedge clock_in);
        chk({7'h00, oe_b}, 8'h01);
        chk(slv.got_q.pop_front(), s);
        // Receiver alone: the data write is refused and no frame runs
        wr(ums_pkg::OFF_ENABLE, 8'h10);
        wr(ums_pkg::OFF_DATA, s);
        repeat (100) @(posedge clock_in);
        rd(ums_pkg::OFF_STATUS);
        chk(rb, 8'h60);
        test_done();
    end
endmodule : tb_usart_master_spi_mode
